// >>> msic_asserts.sv
// concurrent checks on the ports of the slice input control
`timescale 1ns/1ps
`include "msic_defs.svh"
module msic_chk
  import msic_pkg::*;
(
  input wire logic                     core_clk,
  input wire logic                     rstn,
  input wire logic                     reg_rd,
  input wire logic [31:0]              reg_rdata,
  input wire msic_data_in_t            data_in,
  input wire msic_ctrl_in_t            ctrl_in,
  input wire msic_enables_t            enables,
  input wire msic_clears_t             clears,
  input wire logic [`MSIC_OP3_W-1:0]   result_in,
  input wire msic_data_out_t           data_out,
  input wire msic_ctrl_out_t           ctrl_out,
  input wire logic [`MSIC_PROD_W-1:0]  product,
  input wire logic [`MSIC_OP3_W-1:0]   result
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic signed [`MSIC_PROD_W-1:0] prod_exp;
  assign prod_exp = $signed(data_out.mult_op1) * $signed(data_out.mult_op2);
  a_op3_load: assert property (
    enables.op3_reg_enable && !clears.op3_reg_clear
    |=> data_out.op3 == $past(data_in.op3)) else $error("op3 no load");
  a_op3_clear: assert property (
    clears.op3_reg_clear |=> data_out.op3 == '0) else $error("op3 no clear");
  a_out_load: assert property (
    enables.output_reg_enable && !clears.output_reg_clear
    |=> result == $past(result_in)) else $error("result no load");
  a_out_hold: assert property (
    !enables.output_reg_enable && !clears.output_reg_clear
    |=> $stable(result)) else $error("result moved");
  a_prod_load: assert property (
    enables.product_pipe_enable && !clears.product_pipe_clear
    |=> product == $past(prod_exp)) else $error("product wrong");
  a_concat_map: assert property (
    data_out.concat_op == {data_out.op1_cascade_out, data_out.mult_op2}
    && data_out.mult_op1 == data_out.op1_cascade_out[24:0])
    else $error("concat wrong");
  a_sel_clear: assert property (
    clears.select_codes_clear |=> ctrl_out.mux_select_code == '0
    && ctrl_out.carry_source_select == '0) else $error("selects kept");
  a_func_sep: assert property (
    enables.function_code_reg_enable && !clears.function_code_clear
    |=> ctrl_out.function_select_code == $past(ctrl_in.function_select_code))
    else $error("func no load");
  a_carry_clear: assert property (
    clears.carry_regs_clear |=> !ctrl_out.fabric_carry
    && !ctrl_out.internal_carry) else $error("carry kept");
  a_carry_sep: assert property (
    enables.fabric_carry_reg_enable && !enables.internal_carry_reg_enable
    && !clears.carry_regs_clear |=> $stable(ctrl_out.internal_carry)
    && ctrl_out.fabric_carry == $past(ctrl_in.fabric_carry_input))
    else $error("carry enables tied");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data stale");
  c_op3_clr: cover property (enables.op3_reg_enable && clears.op3_reg_clear);
  c_prod: cover property (enables.product_pipe_enable);
  c_carry: cover property (clears.carry_regs_clear);
endmodule
bind msic_input_ctrl msic_chk u_chk (.core_clk, .rstn, .reg_rd, .reg_rdata,
  .data_in, .ctrl_in, .enables, .clears, .result_in, .data_out, .ctrl_out,
  .product, .result);

// >>> msic_defs.svh
// offsets, field positions, reset values and sizes for the slice input control
`ifndef MSIC_DEFS_SVH
`define MSIC_DEFS_SVH

`define MSIC_ADDR_W        8
`define MSIC_OFS_CFG       8'h00
`define MSIC_OFS_STATUS    8'h04
`define MSIC_OFS_DIRECT    8'h08

`define MSIC_CFG_OP1_DEPTH 1:0
`define MSIC_CFG_OP2_DEPTH 3:2
`define MSIC_CFG_OP1_CASC  4
`define MSIC_CFG_OP2_CASC  5
`define MSIC_CFG_W         6
`define MSIC_CFG_RESET     6'h0A

`define MSIC_ST_MUX        6:0
`define MSIC_ST_FUNC       10:7
`define MSIC_ST_CSEL       13:11
`define MSIC_ST_FCARRY     14
`define MSIC_ST_ICARRY     15

`define MSIC_OP1_W         30
`define MSIC_OP2_W         18
`define MSIC_OP3_W         48
`define MSIC_MULT_A_W      25
`define MSIC_PROD_W        43
`define MSIC_MUX_W         7
`define MSIC_FUNC_W        4
`define MSIC_CSEL_W        3

`endif

// >>> msic_input_ctrl.sv
// input registers, pipeline depth control and control-code registers
`timescale 1ns/1ps
`include "msic_defs.svh"

module msic_input_ctrl
  import msic_pkg::*;
(
  input  wire logic                         core_clk,
  input  wire logic                         rstn,
  input  wire logic [`MSIC_ADDR_W-1:0]      reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [31:0]                  reg_rdata,
  input  wire msic_data_in_t                data_in,
  input  wire msic_ctrl_in_t                ctrl_in,
  input  wire msic_enables_t                enables,
  input  wire msic_clears_t                 clears,
  input  wire logic [`MSIC_OP3_W-1:0]       result_in,
  output msic_data_out_t                    data_out,
  output msic_ctrl_out_t                    ctrl_out,
  output logic      [`MSIC_PROD_W-1:0]      product,
  output logic      [`MSIC_OP3_W-1:0]       result
);

  // one register stage is loaded when its enable is high and the
  // configured depth uses it: the second stage at depth 1 or 2, the first stage at depth 2 only
  function automatic logic stage_used(input msic_depth_t depth,
                                      input logic        first);
    if (first)
      stage_used = (depth >= 2'd2);
    else
      stage_used = (depth != 2'd0);
  endfunction

  // depth 3 is not a legal setting and behaves as depth 2
  function automatic logic [1:0] clamp_depth(input logic [1:0] d);
    clamp_depth = (d == 2'd3) ? 2'd2 : d;
  endfunction

  logic [`MSIC_CFG_W-1:0]    cfg_r,      cfg_nxt;
  logic [31:0]               rdata_r,    rdata_nxt;
  logic [`MSIC_OP1_W-1:0]    op1_a_r,    op1_a_nxt;
  logic [`MSIC_OP1_W-1:0]    op1_b_r,    op1_b_nxt;
  logic [`MSIC_OP2_W-1:0]    op2_a_r,    op2_a_nxt;
  logic [`MSIC_OP2_W-1:0]    op2_b_r,    op2_b_nxt;
  logic [`MSIC_OP3_W-1:0]    op3_r,      op3_nxt;
  logic [`MSIC_PROD_W-1:0]   prod_r,     prod_nxt;
  logic [`MSIC_OP3_W-1:0]    res_r,      res_nxt;
  logic [`MSIC_MUX_W-1:0]    mux_r,      mux_nxt;
  logic [`MSIC_CSEL_W-1:0]   csel_r,     csel_nxt;
  logic [`MSIC_FUNC_W-1:0]   func_r,     func_nxt;
  logic                      fcarry_r,   fcarry_nxt;
  logic                      icarry_r,   icarry_nxt;

  msic_depth_t               op1_depth;
  msic_depth_t               op2_depth;
  logic [`MSIC_OP1_W-1:0]    op1_src;
  logic [`MSIC_OP2_W-1:0]    op2_src;
  logic [`MSIC_OP1_W-1:0]    op1_eff;
  logic [`MSIC_OP2_W-1:0]    op2_eff;
  logic [`MSIC_PROD_W-1:0]   mult_full;

  assign op1_depth = clamp_depth(cfg_r[`MSIC_CFG_OP1_DEPTH]);
  assign op2_depth = clamp_depth(cfg_r[`MSIC_CFG_OP2_DEPTH]);

  // cascade or direct source ahead of the first register stage
  assign op1_src = cfg_r[`MSIC_CFG_OP1_CASC] ?
                   data_in.op1_cascade_in : data_in.op1;
  assign op2_src = cfg_r[`MSIC_CFG_OP2_CASC] ?
                   data_in.op2_cascade_in : data_in.op2;

  // operand seen by the datapath after the configured number of stages
  always_comb begin
    unique case (op1_depth)
      2'd0:    op1_eff = op1_src;
      2'd1:    op1_eff = op1_b_r;
      default: op1_eff = op1_b_r;
    endcase
    unique case (op2_depth)
      2'd0:    op2_eff = op2_src;
      2'd1:    op2_eff = op2_b_r;
      default: op2_eff = op2_b_r;
    endcase
  end

  // signed 25x18 product feeding the product pipe register
  assign mult_full = `MSIC_PROD_W'($signed(op1_eff[`MSIC_MULT_A_W-1:0]) *
                                   $signed(op2_eff));

  // ---------------- operand registers ----------------
  always_comb begin
    op1_a_nxt = op1_a_r;
    op1_b_nxt = op1_b_r;
    op2_a_nxt = op2_a_r;
    op2_b_nxt = op2_b_r;
    if (!rstn || clears.op1_regs_clear) begin
      op1_a_nxt = '0;
      op1_b_nxt = '0;
    end else begin
      if (enables.op1_first_reg_enable && stage_used(op1_depth, 1'b1))
        op1_a_nxt = op1_src;
      if (enables.op1_second_reg_enable && stage_used(op1_depth, 1'b0))
        op1_b_nxt = (op1_depth == 2'd2) ? op1_a_r : op1_src;
    end
    if (!rstn || clears.op2_regs_clear) begin
      op2_a_nxt = '0;
      op2_b_nxt = '0;
    end else begin
      if (enables.op2_first_reg_enable && stage_used(op2_depth, 1'b1))
        op2_a_nxt = op2_src;
      if (enables.op2_second_reg_enable && stage_used(op2_depth, 1'b0))
        op2_b_nxt = (op2_depth == 2'd2) ? op2_a_r : op2_src;
    end
  end

  always_ff @(posedge core_clk) begin
    op1_a_r <= op1_a_nxt;
    op1_b_r <= op1_b_nxt;
    op2_a_r <= op2_a_nxt;
    op2_b_r <= op2_b_nxt;
  end

  // ---------------- op3, product pipe, output ----------------
  always_comb begin
    op3_nxt  = op3_r;
    prod_nxt = prod_r;
    res_nxt  = res_r;
    if (!rstn || clears.op3_reg_clear)
      op3_nxt = '0;
    else if (enables.op3_reg_enable)
      op3_nxt = data_in.op3;
    if (!rstn || clears.product_pipe_clear)
      prod_nxt = '0;
    else if (enables.product_pipe_enable)
      prod_nxt = mult_full;
    if (!rstn || clears.output_reg_clear)
      res_nxt = '0;
    else if (enables.output_reg_enable)
      res_nxt = result_in;
  end

  always_ff @(posedge core_clk) begin
    op3_r  <= op3_nxt;
    prod_r <= prod_nxt;
    res_r  <= res_nxt;
  end

  // ---------------- control-code and carry registers ----------------
  always_comb begin
    mux_nxt    = mux_r;
    csel_nxt   = csel_r;
    func_nxt   = func_r;
    fcarry_nxt = fcarry_r;
    icarry_nxt = icarry_r;
    if (!rstn || clears.select_codes_clear) begin
      mux_nxt  = '0;
      csel_nxt = '0;
    end else if (enables.select_codes_reg_enable) begin
      mux_nxt  = ctrl_in.mux_select_code;
      csel_nxt = ctrl_in.carry_source_select;
    end
    if (!rstn || clears.function_code_clear)
      func_nxt = '0;
    else if (enables.function_code_reg_enable)
      func_nxt = ctrl_in.function_select_code;
    if (!rstn || clears.carry_regs_clear) begin
      fcarry_nxt = 1'b0;
      icarry_nxt = 1'b0;
    end else begin
      if (enables.fabric_carry_reg_enable)
        fcarry_nxt = ctrl_in.fabric_carry_input;
      if (enables.internal_carry_reg_enable)
        icarry_nxt = ctrl_in.internal_carry_in;
    end
  end

  always_ff @(posedge core_clk) begin
    mux_r    <= mux_nxt;
    csel_r   <= csel_nxt;
    func_r   <= func_nxt;
    fcarry_r <= fcarry_nxt;
    icarry_r <= icarry_nxt;
  end

  // ---------------- register port ----------------
  // read data is valid only in the cycle after the read strobe
  always_comb begin
    cfg_nxt   = cfg_r;
    rdata_nxt = '0;
    if (!rstn) begin
      cfg_nxt = `MSIC_CFG_RESET;
    end else begin
      if (reg_wr && reg_addr == `MSIC_OFS_CFG)
        cfg_nxt = reg_wdata[`MSIC_CFG_W-1:0];
      if (reg_rd) begin
        unique case (reg_addr)
          `MSIC_OFS_CFG:
            rdata_nxt = {26'h0, cfg_r};
          `MSIC_OFS_STATUS: begin
            rdata_nxt[`MSIC_ST_MUX]    = mux_r;
            rdata_nxt[`MSIC_ST_FUNC]   = func_r;
            rdata_nxt[`MSIC_ST_CSEL]   = csel_r;
            rdata_nxt[`MSIC_ST_FCARRY] = fcarry_r;
            rdata_nxt[`MSIC_ST_ICARRY] = icarry_r;
          end
          `MSIC_OFS_DIRECT:
            rdata_nxt = {2'h0, op1_eff};
          default:
            rdata_nxt = '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    cfg_r   <= cfg_nxt;
    rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

  // ---------------- outputs ----------------
  always_comb begin
    data_out.mult_op1        = op1_eff[`MSIC_MULT_A_W-1:0];
    data_out.mult_op2        = op2_eff;
    data_out.concat_op       = {op1_eff, op2_eff};
    data_out.op3             = op3_r;
    data_out.op1_cascade_out = op1_eff;
    data_out.op2_cascade_out = op2_eff;
    ctrl_out.mux_select_code      = mux_r;
    ctrl_out.function_select_code = func_r;
    ctrl_out.carry_source_select  = csel_r;
    ctrl_out.fabric_carry         = fcarry_r;
    ctrl_out.internal_carry       = icarry_r;
  end

  assign product = prod_r;
  assign result  = res_r;

endmodule

// >>> msic_nbr_model.sv
// neighbouring slice that feeds the cascade operand inputs
`timescale 1ns/1ps
module msic_nbr_model (
  input  wire logic        core_clk,
  input  wire logic        load,
  input  wire logic [29:0] v1,
  input  wire logic [17:0] v2,
  output logic      [29:0] casc1,
  output logic      [17:0] casc2
);
  // a real neighbour drives its cascade from a register, never a wire
  always_ff @(posedge core_clk) begin
    if (load) begin
      casc1 <= v1;
      casc2 <= v2;
    end
  end
endmodule

// >>> msic_pkg.sv
// types shared by the slice input control
package msic_pkg;
  `include "msic_defs.svh"

  typedef logic [1:0] msic_depth_t;

  typedef struct packed {
    logic [`MSIC_OP1_W-1:0] op1;
    logic [`MSIC_OP2_W-1:0] op2;
    logic [`MSIC_OP3_W-1:0] op3;
    logic [`MSIC_OP1_W-1:0] op1_cascade_in;
    logic [`MSIC_OP2_W-1:0] op2_cascade_in;
  } msic_data_in_t;

  typedef struct packed {
    logic [`MSIC_MUX_W-1:0]  mux_select_code;
    logic [`MSIC_FUNC_W-1:0] function_select_code;
    logic [`MSIC_CSEL_W-1:0] carry_source_select;
    logic                    fabric_carry_input;
    logic                    internal_carry_in;
  } msic_ctrl_in_t;

  typedef struct packed {
    logic op1_first_reg_enable;
    logic op1_second_reg_enable;
    logic op2_first_reg_enable;
    logic op2_second_reg_enable;
    logic op3_reg_enable;
    logic product_pipe_enable;
    logic output_reg_enable;
    logic select_codes_reg_enable;
    logic fabric_carry_reg_enable;
    logic function_code_reg_enable;
    logic internal_carry_reg_enable;
  } msic_enables_t;

  typedef struct packed {
    logic op1_regs_clear;
    logic op2_regs_clear;
    logic op3_reg_clear;
    logic product_pipe_clear;
    logic output_reg_clear;
    logic select_codes_clear;
    logic carry_regs_clear;
    logic function_code_clear;
  } msic_clears_t;

  typedef struct packed {
    logic [`MSIC_MULT_A_W-1:0] mult_op1;
    logic [`MSIC_OP2_W-1:0]    mult_op2;
    logic [`MSIC_OP3_W-1:0]    concat_op;
    logic [`MSIC_OP3_W-1:0]    op3;
    logic [`MSIC_OP1_W-1:0]    op1_cascade_out;
    logic [`MSIC_OP2_W-1:0]    op2_cascade_out;
  } msic_data_out_t;

  typedef struct packed {
    logic [`MSIC_MUX_W-1:0]  mux_select_code;
    logic [`MSIC_FUNC_W-1:0] function_select_code;
    logic [`MSIC_CSEL_W-1:0] carry_source_select;
    logic                    fabric_carry;
    logic                    internal_carry;
  } msic_ctrl_out_t;
endpackage

// >>> testbench.sv
// self-checking bench for the slice input control
`timescale 1ns/1ps
module testbench;
  import msic_pkg::*;
  typedef struct packed {
    logic en; logic clr; logic [47:0] v; logic [47:0] e;
  } msic_row_t;
  logic           core_clk, rstn, reg_wr, reg_rd, nb_load;
  logic [7:0]     reg_addr;
  logic [31:0]    reg_wdata, reg_rdata;
  logic [29:0]    nb1, casc1;
  logic [17:0]    nb2, casc2;
  logic [47:0]    result_in, result;
  logic [42:0]    product;
  logic [15:0]    cv;
  msic_data_in_t  dv, din;
  msic_ctrl_in_t  cin;
  msic_enables_t  en;
  msic_clears_t   clr;
  msic_data_out_t dout;
  msic_ctrl_out_t cout;
  int             bad_count, tests_run, cyc;
  msic_row_t rows [5] = '{'{1'b1, 1'b0, 48'h123456789ABC, 48'h123456789ABC},
    '{1'b0, 1'b0, 48'hFFFF00000000, 48'h123456789ABC},
    '{1'b1, 1'b1, 48'h0000FFFFFFFF, 48'h000000000000},
    '{1'b1, 1'b0, 48'hFFFFFFFFFFFF, 48'hFFFFFFFFFFFF},
    '{1'b0, 1'b1, 48'h000000000001, 48'h000000000000}};
  assign din = {dv.op1, dv.op2, dv.op3, casc1, casc2};
  msic_nbr_model nbr (.core_clk(core_clk), .load(nb_load), .v1(nb1),
    .v2(nb2), .casc1(casc1), .casc2(casc2));
  msic_input_ctrl dut (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_in(din), .ctrl_in(cin),
    .enables(en), .clears(clr), .result_in(result_in), .data_out(dout),
    .ctrl_out(cout), .product(product), .result(result));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task chk(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task sync;
    @(posedge core_clk);
  endtask
  // inputs settle at the edge, outputs are read half a period later
  task run(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    sync; reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    sync; reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    sync; reg_addr <= a; reg_rd <= 1'b1;
    sync; reg_rd <= 1'b0;
    run(0); chk(reg_rdata, e);
  endtask
  task ops(input logic [29:0] a, input logic [17:0] b, input logic f,
           input logic s);
    dv.op1 <= a; dv.op2 <= b;
    en.op1_first_reg_enable <= f; en.op2_first_reg_enable <= f;
    en.op1_second_reg_enable <= s; en.op2_second_reg_enable <= s;
  endtask
  task opc(input logic [29:0] a, input logic [17:0] b);
    chk(dout.op1_cascade_out, a); chk(dout.op2_cascade_out, b);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, nb1, nb2} = '0;
    // neighbour loads a known cascade at the first clock edge, before reset is released
    nb_load = 1'b1;
    {dv, cin, en, clr, result_in, rstn} = '0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      sync; dv.op3 <= rows[i].v; result_in <= rows[i].v;
      en.op3_reg_enable <= rows[i].en; en.output_reg_enable <= rows[i].en;
      clr.op3_reg_clear <= rows[i].clr; clr.output_reg_clear <= rows[i].clr;
      run(1);
      chk(dout.op3, rows[i].e);
      chk(result, rows[i].e);
    end
    $display("test rows done");
    rd(8'h00, 32'h0000000A);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h0);
    rd(8'h0C, 32'h0);
    sync; ops(30'h2AAAAAAA, 18'h15555, 1'b1, 1'b1);
    run(1); opc(30'h0, 18'h0);
    run(1); opc(30'h2AAAAAAA, 18'h15555);
    sync; ops(30'h15555555, 18'h2AAAA, 1'b0, 1'b1);
    run(2); opc(30'h2AAAAAAA, 18'h15555);
    sync; ops(30'h15555555, 18'h2AAAA, 1'b1, 1'b0);
    run(2); opc(30'h2AAAAAAA, 18'h15555);
    sync; ops(30'h15555555, 18'h2AAAA, 1'b0, 1'b1);
    run(1); opc(30'h15555555, 18'h2AAAA);
    sync; ops(30'h3C3C3C3C, 18'h0F0F0, 1'b1, 1'b1);
    clr.op1_regs_clear <= 1'b1; clr.op2_regs_clear <= 1'b1;
    run(1); opc(30'h0, 18'h0);
    sync; clr <= '0; ops(30'h3C3C3C3C, 18'h0F0F0, 1'b0, 1'b1);
    run(1); opc(30'h0, 18'h0);
    wr(8'h00, 32'h00000005);
    sync; ops(30'h0F0F0F0F, 18'h3C3C3, 1'b1, 1'b0);
    run(2); opc(30'h3C3C3C3C, 18'h0F0F0);
    sync; ops(30'h0F0F0F0F, 18'h3C3C3, 1'b0, 1'b1);
    run(1); opc(30'h0F0F0F0F, 18'h3C3C3);
    wr(8'h00, 32'h00000000);
    sync; ops(30'h01FFFFFF, 18'h00003, 1'b0, 1'b0);
    en.product_pipe_enable <= 1'b1;
    run(1); opc(30'h01FFFFFF, 18'h00003);
    chk(dout.mult_op1, 25'h1FFFFFF);
    chk(dout.concat_op, {30'h01FFFFFF, 18'h00003});
    chk(product, 43'h7FFFFFFFFFD);
    sync; clr.product_pipe_clear <= 1'b1;
    run(1); chk(product, 43'h0);
    wr(8'h00, 32'h00000030);
    sync; nb_load <= 1'b1; nb1 <= 30'h12345678; nb2 <= 18'h0ABCD;
    run(1); opc(30'h12345678, 18'h0ABCD);
    rd(8'h08, 32'h12345678);
    $display("test operands done");
    sync; en <= '1; clr <= '0;
    for (int i = 0; i < 16; i++) begin
      cv = {7'(i * 9), 4'(i), 3'(i), i[0], i[1]};
      sync; cin <= cv;
      run(1); chk(cout, cv);
    end
    sync; cin <= 16'h0; en.function_code_reg_enable <= 1'b0;
    run(1); chk(cout, 16'h01E0);
    sync; cin <= 16'hFFFF; en.function_code_reg_enable <= 1'b1;
    clr.select_codes_clear <= 1'b1; clr.carry_regs_clear <= 1'b1;
    run(1); chk(cout, 16'h01E0);
    sync; clr <= 8'h01;
    run(1); chk(cout, 16'hFE1F);
    rd(8'h04, 32'h0000F87F);
    sync; clr <= '0; cin <= 16'h0; en.internal_carry_reg_enable <= 1'b0;
    run(1); chk(cout, 16'h0001);
    $display("test controls done");
    sync; rstn <= 1'b0;
    sync; rstn <= 1'b1;
    run(0); chk(cout, 16'h0);
    rd(8'h00, 32'h0000000A);
    $display("test reset done");
    test_done;
  end
endmodule
